// ===== ttc_pkg.sv
// ttc_pkg: constants and types shared by the thermal throttle controller files
// assumes a 20 MHz core clock; all times are turned into cycle counts here
package ttc_pkg;
    localparam int unsigned CLOCK_HZ        = 20_000_000;
    localparam int unsigned CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
    // modulation timing: off interval at most 3.0 us, fixed duty about 40 % on
    localparam int unsigned MOD_OFF_MAX_NS  = 3000;
    localparam int unsigned MOD_OFF_CYC     = MOD_OFF_MAX_NS / CLOCK_PERIOD_NS;
    localparam int unsigned MOD_ON_CYC      = (MOD_OFF_CYC * 2) / 3;
    // frequency switch time, about 5 us
    localparam int unsigned FSWITCH_NS      = 5000;
    localparam int unsigned FSWITCH_CYC     = (FSWITCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // voltage code and ratio widths
    localparam int unsigned VID_W           = 6;
    localparam int unsigned RATIO_W         = 5;
    localparam int unsigned CNT_W           = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
    localparam logic [VID_W-1:0] VID_ONE    = 6'h01;

    typedef enum logic {
        TTC_MODE_MODULATE,
        TTC_MODE_FREQ_VOLT
    } ttc_mode_e;

    typedef enum {
        TTC_NORMAL,
        TTC_FSWITCH_DOWN,
        TTC_VID_DOWN,
        TTC_THROTTLED,
        TTC_VID_UP,
        TTC_FSWITCH_UP
    } ttc_fv_state_e;
endpackage : ttc_pkg

// ===== ttc_hyst_if.sv
// ttc_hyst_if: carries the hot level into the hysteresis timer and its verdict out
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface ttc_hyst_if;
    logic hot;
    logic active;
    modport ctrl  (output hot, input active);
    modport timer (input hot, output active);
endinterface : ttc_hyst_if
`default_nettype wire

// ===== ttc_hyst_timer.sv
// ttc_hyst_timer: holds the thermal control circuit active until the die has been
// below the limit for a full hysteresis period
// assumes a synchronous hot level and a released active-low reset
`timescale 1ns/1ps
`default_nettype none
module ttc_hyst_timer #(
    parameter int unsigned HYST_CYC = 1000
) (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    // hysteresis link
    ttc_hyst_if.timer hyst
);
    import ttc_pkg::*;

    // the hold assertion below spans eight cycles, so shorter timers are refused
    if (HYST_CYC < 8 || HYST_CYC >= (1 << CNT_W)) begin : g_bad_hyst
        $error("HYST_CYC out of range");
    end

    localparam logic [CNT_W-1:0] HYST_LOAD = CNT_W'(HYST_CYC);
    logic [CNT_W-1:0] count;
    logic             active;

    // re-arming on every hot cycle stops rapid on/off flapping near the limit
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active <= 1'b0;
            count  <= CNT_ZERO;
        end else if (hyst.hot) begin
            active <= 1'b1;
            count  <= HYST_LOAD;
        end else if (active && count == CNT_ONE) begin
            active <= 1'b0;
            count  <= CNT_ZERO;
        end else if (active) begin
            count  <= count - CNT_ONE;
        end
    end
    assign hyst.active = active;

    property p_hyst_hold;
        @(posedge clock_in) disable iff (!reset_n_in)
        $fell(hyst.hot) |-> hyst.active [*8];
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("left active too soon");
endmodule : ttc_hyst_timer
`default_nettype wire

// ===== ttc_throttle.sv
// ttc_throttle: on-die thermal throttle control, top module
// What this block does
// - modulate core clock at fixed duty when active
// - each clock-off interval at most 3.0 us
// - duty cycle fixed, no input changes it
// - trip threshold internal, not configurable or visible
// - keep snooping, latch interrupts, serve when on
// - deactivate only after cool plus hysteresis expiry
// - two operating points, normal and throttled
// - activation first drops frequency, about 5 us
// - block bus requests during frequency switch
// - latch edge interrupts during frequency switch
// - step voltage code one entry at a time
// - keep executing while voltage code steps
// - exit restores voltage first, then frequency
// - thermal alert low whenever die is hot
// assumes die_hot_in comes from the internal sensor comparator, synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none
module ttc_throttle #(
    parameter int unsigned            HYST_CYC   = 1000,
    parameter logic [ttc_pkg::RATIO_W-1:0] LOW_RATIO = 5'h0_8,
    parameter logic [ttc_pkg::VID_W-1:0]   LOW_VID   = 6'h1_8
) (
    // clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         reset_n_in,
    // thermal sensing and configuration
    input  wire logic                         die_hot_in,
    input  wire ttc_pkg::ttc_mode_e           mode_in,
    input  wire logic [ttc_pkg::RATIO_W-1:0]  normal_ratio_in,
    input  wire logic [ttc_pkg::VID_W-1:0]    normal_vid_in,
    // interrupts
    input  wire logic                         irq_edge_in,
    input  wire logic                         irq_ack_in,
    output logic                              irq_service_out,
    // bus and core
    output logic                              bus_block_out,
    output logic                              core_clock_en_out,
    output logic                              snoop_en_out,
    output logic                              exec_en_out,
    // operating point
    output logic [ttc_pkg::RATIO_W-1:0]       ratio_out,
    output logic [ttc_pkg::VID_W-1:0]         voltage_id_code_out,
    output logic                              voltage_id_code_oe_n_out,
    // alert pin
    output logic                              thermal_alert_n_out,
    output logic                              thermal_alert_n_oe_n_out,
    output logic                              tcc_active_out
);
    import ttc_pkg::*;

    if (LOW_RATIO == '0) begin : g_bad_ratio
        $error("LOW_RATIO must be nonzero");
    end

    localparam logic [CNT_W-1:0] OFF_LOAD = CNT_W'(MOD_OFF_CYC - 1);
    localparam logic [CNT_W-1:0] ON_LOAD  = CNT_W'(MOD_ON_CYC - 1);
    localparam logic [CNT_W-1:0] SW_LOAD  = CNT_W'(FSWITCH_CYC - 1);
    localparam int unsigned      OFF_SPAN = MOD_OFF_CYC;

    logic rst_meta, reset_n;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            reset_n  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            reset_n  <= rst_meta;
        end
    end

    // the trip point lives in the sensor; no register reaches it
    ttc_hyst_if hyst ();
    assign hyst.hot = die_hot_in;
    ttc_hyst_timer #(.HYST_CYC(HYST_CYC)) u_hyst (
        .clock_in   (clock_in),
        .reset_n_in (reset_n),
        .hyst       (hyst)
    );
    logic active;
    assign active = hyst.active;

    // clock modulation; duty comes from package constants only
    logic             mod_on;
    logic [CNT_W-1:0] mod_cnt;
    always_ff @(posedge clock_in or negedge reset_n) begin
        if (!reset_n) begin
            mod_on  <= 1'b1;
            mod_cnt <= CNT_ZERO;
        end else if (!(active && mode_in == TTC_MODE_MODULATE)) begin
            mod_on  <= 1'b1;
            mod_cnt <= CNT_ZERO;
        end else if (mod_cnt != CNT_ZERO) begin
            mod_cnt <= mod_cnt - CNT_ONE;
        end else begin
            mod_on  <= !mod_on;
            mod_cnt <= mod_on ? OFF_LOAD : ON_LOAD;
        end
    end
    assign core_clock_en_out = mod_on;
    assign snoop_en_out      = 1'b1;

    // frequency / voltage sequencer
    ttc_fv_state_e    state;
    logic [CNT_W-1:0] sw_cnt;
    logic [RATIO_W-1:0] ratio;
    logic [VID_W-1:0]   voltage_id_code;
    logic want_low;
    assign want_low = active && mode_in == TTC_MODE_FREQ_VOLT;

    always_ff @(posedge clock_in or negedge reset_n) begin
        if (!reset_n) begin
            state  <= TTC_NORMAL;
            sw_cnt <= CNT_ZERO;
        end else begin
            unique case (state)
                TTC_NORMAL: begin
                    if (want_low) begin
                        state  <= TTC_FSWITCH_DOWN;
                        sw_cnt <= SW_LOAD;
                    end
                end
                TTC_FSWITCH_DOWN: begin
                    if (sw_cnt == CNT_ZERO) state <= TTC_VID_DOWN;
                    else sw_cnt <= sw_cnt - CNT_ONE;
                end
                TTC_VID_DOWN: begin
                    if (!want_low) state <= TTC_VID_UP;
                    else if (voltage_id_code == LOW_VID) state <= TTC_THROTTLED;
                end
                TTC_THROTTLED: begin
                    if (!want_low) state <= TTC_VID_UP;
                end
                TTC_VID_UP: begin
                    if (voltage_id_code == normal_vid_in) begin
                        state  <= TTC_FSWITCH_UP;
                        sw_cnt <= SW_LOAD;
                    end
                end
                TTC_FSWITCH_UP: begin
                    if (sw_cnt == CNT_ZERO) state <= TTC_NORMAL;
                    else sw_cnt <= sw_cnt - CNT_ONE;
                end
            endcase
        end
    end

    // ratio changes at the start of each switch window
    always_ff @(posedge clock_in or negedge reset_n) begin
        if (!reset_n) begin
            ratio <= '0;
        end else if (state == TTC_NORMAL && !want_low) begin
            ratio <= normal_ratio_in;
        end else if (state == TTC_NORMAL) begin
            ratio <= LOW_RATIO;
        end else if (state == TTC_VID_UP && voltage_id_code == normal_vid_in) begin
            ratio <= normal_ratio_in;
        end
    end

    // one code entry per cycle toward the target, down or up
    always_ff @(posedge clock_in or negedge reset_n) begin
        if (!reset_n) begin
            voltage_id_code <= '0;
        end else if (state == TTC_NORMAL || state == TTC_FSWITCH_UP) begin
            voltage_id_code <= normal_vid_in;
        end else if (state == TTC_VID_DOWN && want_low && voltage_id_code != LOW_VID) begin
            voltage_id_code <= (voltage_id_code > LOW_VID) ? voltage_id_code - VID_ONE : voltage_id_code + VID_ONE;
        end else if (state == TTC_VID_UP && voltage_id_code != normal_vid_in) begin
            voltage_id_code <= (voltage_id_code > normal_vid_in) ? voltage_id_code - VID_ONE : voltage_id_code + VID_ONE;
        end
    end

    logic switching;
    assign switching = state == TTC_FSWITCH_DOWN || state == TTC_FSWITCH_UP;
    assign bus_block_out = switching;
    assign exec_en_out   = !switching && mod_on;
    assign ratio_out     = ratio;
    assign voltage_id_code_out      = voltage_id_code;
    assign voltage_id_code_oe_n_out = 1'b0;

    // pending interrupt; a new edge wins over a same-cycle acknowledge
    logic irq_pend;
    always_ff @(posedge clock_in or negedge reset_n) begin
        if (!reset_n) irq_pend <= 1'b0;
        else if (irq_edge_in) irq_pend <= 1'b1;
        else if (irq_ack_in) irq_pend <= 1'b0;
    end
    assign irq_service_out = irq_pend && mod_on && !switching;

    // open-drain alert: drive low while hot, regardless of mode
    assign thermal_alert_n_out      = 1'b0;
    assign thermal_alert_n_oe_n_out = !die_hot_in;
    assign tcc_active_out           = active;

    property p_off_bound;
        @(posedge clock_in) disable iff (!reset_n)
        $fell(mod_on) |-> ##[1:OFF_SPAN] mod_on;
    endproperty
    a_off_bound: assert property (p_off_bound) else $error("clock off too long");

    property p_mod_only_active;
        @(posedge clock_in) disable iff (!reset_n)
        !active |=> mod_on;
    endproperty
    a_mod_only_active: assert property (p_mod_only_active) else $error("stray modulation");

    property p_switch_len;
        @(posedge clock_in) disable iff (!reset_n)
        $rose(switching) |-> switching [*8];
    endproperty
    a_switch_len: assert property (p_switch_len) else $error("switch too short");

    property p_block;
        @(posedge clock_in) disable iff (!reset_n)
        switching |-> bus_block_out && !irq_service_out;
    endproperty
    a_block: assert property (p_block) else $error("bus open in switch");

    property p_vid_step;
        @(posedge clock_in) disable iff (!reset_n)
        (state == TTC_VID_DOWN && $past(state) == TTC_VID_DOWN)
            |-> (voltage_id_code == $past(voltage_id_code) - VID_ONE || voltage_id_code == $past(voltage_id_code) + VID_ONE || voltage_id_code == $past(voltage_id_code));
    endproperty
    a_vid_step: assert property (p_vid_step) else $error("code jumped");

    property p_vid_first;
        @(posedge clock_in) disable iff (!reset_n)
        (state == TTC_FSWITCH_UP) |-> voltage_id_code == normal_vid_in;
    endproperty
    a_vid_first: assert property (p_vid_first) else $error("frequency before voltage");

    property p_alert;
        @(posedge clock_in) disable iff (!reset_n)
        die_hot_in |-> !thermal_alert_n_oe_n_out;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing");

    property p_irq_keep;
        @(posedge clock_in) disable iff (!reset_n)
        irq_edge_in |=> irq_pend;
    endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("interrupt lost");
endmodule : ttc_throttle
`default_nettype wire

// ===== ttc_vr_model.sv
// ttc_vr_model: voltage regulator and fan controller facing the throttle block
// assumes one core clock and open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module ttc_vr_model (
    // clock and watch enable
    input  wire logic       clock_in,
    input  wire logic       arm_in,
    // device pins
    input  wire logic [5:0] vid_in,
    input  wire logic       vid_oe_n_in,
    input  wire logic       alert_n_in,
    input  wire logic       alert_oe_n_in,
    // regulator and fan state
    output logic [5:0]      vout_code_out,
    output logic            step_err_out,
    output logic            fan_full_out
);
    // released lines float up to the pull-up level
    wire logic [5:0] vid_line = vid_oe_n_in ? 6'h3_F : vid_in;
    wire logic       alert    = alert_oe_n_in ? 1'b1 : alert_n_in;
    always @(posedge clock_in) begin
        vout_code_out <= vid_line;
        // jumps larger than one code would upset a stepping regulator
        if (!arm_in) begin
            step_err_out <= 1'b0;
        end else if (vid_line != vout_code_out && vid_line + 6'h0_1 != vout_code_out
            && vout_code_out + 6'h0_1 != vid_line) begin
            step_err_out <= 1'b1;
        end
    end
    assign fan_full_out = !alert;
endmodule : ttc_vr_model
`default_nettype wire

// ===== testbench.sv
// testbench: drives the throttle block through both throttle modes
// assumes the block's assertions sit in its own files
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ttc_pkg::*;
    localparam int unsigned HY = 10;
    localparam logic [4:0]  NR = 5'h1_0;
    localparam logic [4:0]  LR = 5'h0_8;
    localparam logic [5:0]  NV = 6'h2_0;
    localparam logic [5:0]  LV = 6'h1_8;
    logic       clock_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       die_hot_in = 1'b0;
    ttc_mode_e  mode_in = TTC_MODE_MODULATE;
    logic       irq_edge_in = 1'b0;
    logic       irq_ack_in = 1'b0;
    logic       arm = 1'b0;
    logic       irq_service_out, bus_block_out, core_clock_en_out, snoop_en_out;
    logic       exec_en_out, vid_oe_n, alert_n, alert_oe_n, tcc_active_out;
    logic       step_err, fan_full;
    logic [4:0] ratio_out;
    logic [5:0] voltage_id_code, vout;
    int         errors = 0;
    int         comparisons = 0;

    always #25 clock_in = ~clock_in;

    ttc_throttle #(.HYST_CYC(HY), .LOW_RATIO(LR), .LOW_VID(LV)) DUT (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .die_hot_in(die_hot_in),
        .mode_in(mode_in), .normal_ratio_in(NR), .normal_vid_in(NV),
        .irq_edge_in(irq_edge_in), .irq_ack_in(irq_ack_in),
        .irq_service_out(irq_service_out), .bus_block_out(bus_block_out),
        .core_clock_en_out(core_clock_en_out), .snoop_en_out(snoop_en_out),
        .exec_en_out(exec_en_out), .ratio_out(ratio_out), .voltage_id_code_out(voltage_id_code),
        .voltage_id_code_oe_n_out(vid_oe_n), .thermal_alert_n_out(alert_n),
        .thermal_alert_n_oe_n_out(alert_oe_n), .tcc_active_out(tcc_active_out));

    ttc_vr_model vr (.clock_in(clock_in), .arm_in(arm), .vid_in(voltage_id_code),
        .vid_oe_n_in(vid_oe_n), .alert_n_in(alert_n), .alert_oe_n_in(alert_oe_n),
        .vout_code_out(vout), .step_err_out(step_err), .fan_full_out(fan_full));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic t_reset;
        repeat (6) @(negedge clock_in);
        chk(core_clock_en_out, 1'b1);
        chk(bus_block_out | tcc_active_out, 1'b0);
        @(posedge clock_in) reset_n_in <= 1'b1;
        repeat (5) @(negedge clock_in);
        chk(ratio_out, NR);
        chk(voltage_id_code, NV);
        chk(fan_full, 1'b0);
        @(posedge clock_in) arm <= 1'b1;
    endtask : t_reset

    task automatic t_modulate;
        int n;
        @(posedge clock_in) die_hot_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        chk(tcc_active_out, 1'b1);
        chk(fan_full, 1'b1);
        n = 0;
        while (core_clock_en_out !== 1'b0 && n < 10) begin
            @(negedge clock_in);
            n++;
        end
        n = 0;
        while (core_clock_en_out === 1'b0 && n < 200) begin
            chk(snoop_en_out, 1'b1);
            chk(exec_en_out, 1'b0);
            chk(irq_service_out, 1'b0);
            @(posedge clock_in) irq_edge_in <= (n == 3);
            @(negedge clock_in);
            n++;
        end
        chk(n, MOD_OFF_CYC);
        n = 0;
        while (core_clock_en_out === 1'b1 && n < 200) begin
            if (n == 2) chk(irq_service_out, 1'b1);
            if (n == 6) chk(irq_service_out, 1'b0);
            @(posedge clock_in) irq_ack_in <= (n == 3);
            @(negedge clock_in);
            n++;
        end
        chk(n, MOD_ON_CYC);
        @(posedge clock_in) die_hot_in <= 1'b0;
        n = 0;
        @(negedge clock_in);
        while (tcc_active_out === 1'b1 && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        chk(n, HY);
        n = 0;
        repeat (80) begin
            @(negedge clock_in);
            if (core_clock_en_out !== 1'b1) n++;
        end
        chk(n, 0);
    endtask : t_modulate

    task automatic t_freq_volt;
        int n;
        @(posedge clock_in) mode_in <= TTC_MODE_FREQ_VOLT;
        @(posedge clock_in) die_hot_in <= 1'b1;
        @(negedge clock_in);
        n = 0;
        while (bus_block_out !== 1'b1 && n < 10) begin
            @(negedge clock_in);
            n++;
        end
        chk(ratio_out, LR);
        n = 0;
        while (bus_block_out === 1'b1 && n < 300) begin
            chk(irq_service_out, 1'b0);
            chk(exec_en_out, 1'b0);
            @(posedge clock_in) irq_edge_in <= (n == 5);
            @(negedge clock_in);
            n++;
        end
        chk(n, FSWITCH_CYC);
        n = 0;
        while (voltage_id_code !== LV && n < 60) begin
            chk(exec_en_out, 1'b1);
            chk(bus_block_out, 1'b0);
            if (n == 1) chk(irq_service_out, 1'b1);
            @(posedge clock_in) irq_ack_in <= (n == 1);
            @(negedge clock_in);
            n++;
        end
        chk(voltage_id_code, LV);
        chk(ratio_out, LR);
        chk(fan_full, 1'b1);
        @(posedge clock_in) die_hot_in <= 1'b0;
        @(negedge clock_in);
        chk(vout, LV);
        n = 0;
        while (bus_block_out !== 1'b1 && n < 200) begin
            if (voltage_id_code !== NV) chk(ratio_out, LR);
            @(negedge clock_in);
            n++;
        end
        chk(voltage_id_code, NV);
        repeat (FSWITCH_CYC + 2) @(negedge clock_in);
        chk(ratio_out, NR);
        chk(bus_block_out | tcc_active_out, 1'b0);
        chk(step_err, 1'b0);
        chk(vout, NV);
    endtask : t_freq_volt

    initial begin
        t_reset();
        t_modulate();
        t_freq_volt();
        conclude();
    end

    // the run needs under 500 cycles; allow forty times that
    initial begin
        #1_000_000;
        errors++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
